// file: design/fcm_pkg.sv
// Purpose: constants and types for the flash register map and id words
// Assumes: 16-bit word registers, one system clock, synchronous reset
// Notes  : id codes below are arbitrary neutral values
package fcm_pkg;
   // ==========================================================
   // internal bus offsets (byte addresses, 20 bits)
   localparam logic [19:0] FCM_OFF_FLASH_CONTROL0_LOW    = 20'h80000;
   localparam logic [19:0] FCM_OFF_FLASH_CONTROL0_HIGH    = 20'h80002;
   localparam logic [19:0] FCM_OFF_FLASH_CONTROL1_LOW    = 20'h80004;
   localparam logic [19:0] FCM_OFF_FLASH_CONTROL1_HIGH    = 20'h80006;
   localparam logic [19:0] FCM_OFF_FLASH_DATA0_LOW    = 20'h80008;
   localparam logic [19:0] FCM_OFF_FLASH_DATA0_HIGH    = 20'h8000a;
   localparam logic [19:0] FCM_OFF_FLASH_DATA1_LOW    = 20'h8000c;
   localparam logic [19:0] FCM_OFF_FLASH_DATA1_HIGH    = 20'h8000e;
   localparam logic [19:0] FCM_OFF_FLASH_ADDRESS_LOW     = 20'h80010;
   localparam logic [19:0] FCM_OFF_FLASH_ADDRESS_HIGH     = 20'h80012;
   localparam logic [19:0] FCM_OFF_FER      = 20'h80014;
   localparam logic [19:0] FCM_OFF_NVWP     = 20'h8dfb0;
   localparam logic [19:0] FCM_OFF_NVAP0    = 20'h8dfb8;
   localparam logic [19:0] FCM_OFF_NVAP1L   = 20'h8dfbc;
   localparam logic [19:0] FCM_OFF_NVAP1H   = 20'h8dfbe;
   localparam int          FCM_NREG         = 15;
   // ==========================================================
   // peripheral bus and id space offsets
   localparam logic [15:0] FCM_OFF_UNPROT   = 16'heb50;
   localparam logic [15:0] FCM_OFF_ID_MAKER = 16'hf070;
   localparam logic [15:0] FCM_OFF_ID_CHIP  = 16'hf07c;
   localparam logic [15:0] FCM_OFF_ID_MEM   = 16'hf07a;
   localparam logic [15:0] FCM_OFF_ID_PROG  = 16'hf078;
   localparam int          FCM_MISC_EN_BIT  = 10;
   // ==========================================================
   // reset values
   localparam logic [15:0] FCM_RST_ZERO     = 16'h0000;
   localparam logic [15:0] FCM_RST_ONES     = 16'hffff;
   localparam logic [15:0] FCM_RST_NVAP0    = 16'hacff;
   // ==========================================================
   // id field values (maker and device codes arbitrary)
   localparam logic [10:0] FCM_MAKER_CODE   = 11'h05a;
   localparam logic [11:0] FCM_DEVICE_CODE  = 12'h5a5;
   localparam logic [3:0]  FCM_REVISION     = 4'h1;
   localparam logic [3:0]  FCM_CAPACITY     = 4'h0;
   localparam logic [11:0] FCM_KIND_NONE    = 12'h000;
   localparam logic [11:0] FCM_KIND_MROM    = 12'h001;
   localparam logic [11:0] FCM_KIND_SFLASH  = 12'h002;
   localparam logic [11:0] FCM_KIND_HFLASH  = 12'h003;
   localparam logic [7:0]  FCM_EXT_SUPPLY   = 8'h00;
   localparam logic [7:0]  FCM_CORE_SUPPLY  = 8'h40;
   localparam logic [4:0]  FCM_MAKER_PAD    = 5'h00;

   typedef struct packed {
      logic        sel;
      logic        wr;
      logic        bitop;
      logic [19:0] addr;
      logic [15:0] wdata;
   } fcm_req_t;

   typedef enum logic [1:0] {
      FCM_ANS_OK   = 2'b00,
      FCM_ANS_REF  = 2'b01,
      FCM_ANS_UNM  = 2'b10
   } fcm_ans_t;
endpackage

// file: design/fcm_regs.sv
// Purpose: flash control register map, unprotect register, id words
// Assumes: one-cycle buses, same clock domain as requesters
// Notes  : answer and read data valid the cycle after the request
`timescale 1ns/100ps
module fcm_regs
   import fcm_pkg::*;
(
   input  wire logic          clock_i,
   input  wire logic          sys_rst_i,
   input  wire fcm_req_t      internal_memory_bus_req_i,
   input  wire fcm_req_t      xbus_req_i,
   input  wire fcm_req_t      sfr_req_i,
   input  wire logic          misc_window_enable_i,
   output logic               internal_memory_bus_ack_o,
   output fcm_ans_t           internal_memory_bus_ans_o,
   output logic [15:0]        internal_memory_bus_rdata_o,
   output logic               xbus_ack_o,
   output fcm_ans_t           xbus_ans_o,
   output logic [15:0]        xbus_rdata_o,
   output logic               sfr_ack_o,
   output fcm_ans_t           sfr_ans_o,
   output logic [15:0]        sfr_rdata_o,
   output logic [15:0]        flash_control0_low_o,
   output logic [15:0]        volatile_unprotect_temp_o
);
   // ==========================================================
   // address decode
   function automatic int internal_memory_bus_index(input logic [19:0] a);
      case (a)
         FCM_OFF_FLASH_CONTROL0_LOW:  internal_memory_bus_index = 0;
         FCM_OFF_FLASH_CONTROL0_HIGH:  internal_memory_bus_index = 1;
         FCM_OFF_FLASH_CONTROL1_LOW:  internal_memory_bus_index = 2;
         FCM_OFF_FLASH_CONTROL1_HIGH:  internal_memory_bus_index = 3;
         FCM_OFF_FLASH_DATA0_LOW:  internal_memory_bus_index = 4;
         FCM_OFF_FLASH_DATA0_HIGH:  internal_memory_bus_index = 5;
         FCM_OFF_FLASH_DATA1_LOW:  internal_memory_bus_index = 6;
         FCM_OFF_FLASH_DATA1_HIGH:  internal_memory_bus_index = 7;
         FCM_OFF_FLASH_ADDRESS_LOW:   internal_memory_bus_index = 8;
         FCM_OFF_FLASH_ADDRESS_HIGH:   internal_memory_bus_index = 9;
         FCM_OFF_FER:    internal_memory_bus_index = 10;
         FCM_OFF_NVWP:   internal_memory_bus_index = 11;
         FCM_OFF_NVAP0:  internal_memory_bus_index = 12;
         FCM_OFF_NVAP1L: internal_memory_bus_index = 13;
         FCM_OFF_NVAP1H: internal_memory_bus_index = 14;
         default:        internal_memory_bus_index = -1;
      endcase
   endfunction

   function automatic logic [15:0] reset_value(input int i);
      if (i >= 4 && i <= 7) begin
         reset_value = FCM_RST_ONES;
      end else if (i == 11 || i == 13 || i == 14) begin
         reset_value = FCM_RST_ONES;
      end else if (i == 12) begin
         reset_value = FCM_RST_NVAP0;
      end else begin
         reset_value = FCM_RST_ZERO;
      end
   endfunction

   // ==========================================================
   // identification words, constants only
   localparam logic [15:0] ID_MAKER =
      {FCM_MAKER_CODE, FCM_MAKER_PAD};
   localparam logic [15:0] ID_CHIP  =
      {FCM_DEVICE_CODE, FCM_REVISION};
   localparam logic [15:0] ID_MEM   =
      {FCM_CAPACITY, FCM_KIND_SFLASH};
   localparam logic [15:0] ID_PROG  =
      {FCM_EXT_SUPPLY, FCM_CORE_SUPPLY};

   // ==========================================================
   // state
   logic [15:0] regs_r   [FCM_NREG];
   logic [15:0] regs_nxt [FCM_NREG];
   logic [15:0] unprot_r, unprot_nxt;
   // enable level comes from another register: only s2 gates access
   logic        misc_s1_r, misc_s2_r;
   logic        iack_r, iack_nxt, xack_r, xack_nxt, sack_r, sack_nxt;
   fcm_ans_t    ians_r, ians_nxt, xans_r, xans_nxt, sans_r, sans_nxt;
   logic [15:0] irda_r, irda_nxt, xrda_r, xrda_nxt, srda_r, srda_nxt;
   int          idx;

   always_comb begin
      idx = internal_memory_bus_index(internal_memory_bus_req_i.addr);
      for (int i = 0; i < FCM_NREG; i++) begin
         regs_nxt[i] = regs_r[i];
      end
      unprot_nxt = unprot_r;
      iack_nxt = internal_memory_bus_req_i.sel;
      ians_nxt = FCM_ANS_OK;
      irda_nxt = 16'h0000;
      xack_nxt = xbus_req_i.sel;
      xans_nxt = FCM_ANS_OK;
      xrda_nxt = 16'h0000;
      sack_nxt = sfr_req_i.sel;
      sans_nxt = FCM_ANS_OK;
      srda_nxt = 16'h0000;
      // internal bus: only the flash control words live here
      if (internal_memory_bus_req_i.sel) begin
         if (idx < 0) begin
            ians_nxt = FCM_ANS_UNM;
         end else if (internal_memory_bus_req_i.bitop) begin
            ians_nxt = FCM_ANS_REF;
         end else if (internal_memory_bus_req_i.wr) begin
            regs_nxt[idx] = internal_memory_bus_req_i.wdata;
         end else begin
            irda_nxt = regs_r[idx];
         end
      end
      // peripheral bus: unprotect word, gated by window enable
      if (xbus_req_i.sel) begin
         if (xbus_req_i.addr[15:0] != FCM_OFF_UNPROT
             || xbus_req_i.addr[19:16] != 4'h0) begin
            xans_nxt = FCM_ANS_UNM;
         end else if (!misc_s2_r) begin
            xans_nxt = FCM_ANS_REF;
         end else if (xbus_req_i.bitop) begin
            xans_nxt = FCM_ANS_REF;
         end else if (xbus_req_i.wr) begin
            unprot_nxt = xbus_req_i.wdata;
         end else begin
            xrda_nxt = unprot_r;
         end
      end
      // id space: exactly four words, writes dropped quietly
      if (sfr_req_i.sel) begin
         case (sfr_req_i.addr[15:0])
            FCM_OFF_ID_MAKER: srda_nxt = ID_MAKER;
            FCM_OFF_ID_CHIP:  srda_nxt = ID_CHIP;
            FCM_OFF_ID_MEM:   srda_nxt = ID_MEM;
            FCM_OFF_ID_PROG:  srda_nxt = ID_PROG;
            default:          sans_nxt = FCM_ANS_UNM;
         endcase
         if (sfr_req_i.addr[19:16] != 4'h0) begin
            sans_nxt = FCM_ANS_UNM;
            srda_nxt = 16'h0000;
         end else if (sfr_req_i.wr) begin
            srda_nxt = 16'h0000;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < FCM_NREG; i++) begin
            regs_r[i] <= reset_value(i);
         end
         unprot_r  <= FCM_RST_ZERO;
         misc_s1_r <= 1'b0;
         misc_s2_r <= 1'b0;
         iack_r    <= 1'b0;
         ians_r    <= FCM_ANS_OK;
         irda_r    <= 16'h0000;
         xack_r    <= 1'b0;
         xans_r    <= FCM_ANS_OK;
         xrda_r    <= 16'h0000;
         sack_r    <= 1'b0;
         sans_r    <= FCM_ANS_OK;
         srda_r    <= 16'h0000;
      end else begin
         for (int i = 0; i < FCM_NREG; i++) begin
            regs_r[i] <= regs_nxt[i];
         end
         unprot_r  <= unprot_nxt;
         misc_s1_r <= misc_window_enable_i;
         misc_s2_r <= misc_s1_r;
         iack_r    <= iack_nxt;
         ians_r    <= ians_nxt;
         irda_r    <= irda_nxt;
         xack_r    <= xack_nxt;
         xans_r    <= xans_nxt;
         xrda_r    <= xrda_nxt;
         sack_r    <= sack_nxt;
         sans_r    <= sans_nxt;
         srda_r    <= srda_nxt;
      end
   end

   assign internal_memory_bus_ack_o   = iack_r;
   assign internal_memory_bus_ans_o   = ians_r;
   assign internal_memory_bus_rdata_o = irda_r;
   assign xbus_ack_o   = xack_r;
   assign xbus_ans_o   = xans_r;
   assign xbus_rdata_o = xrda_r;
   assign sfr_ack_o    = sack_r;
   assign sfr_ans_o    = sans_r;
   assign sfr_rdata_o  = srda_r;
   assign flash_control0_low_o      = regs_r[0];
   assign volatile_unprotect_temp_o = unprot_r;

   // ==========================================================
   // checks
   default clocking cb_chk @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_id_read(logic [15:0] off);
      sfr_req_i.sel && !sfr_req_i.wr && sfr_req_i.addr == {4'h0, off};
   endsequence
   sequence s_id_write(logic [15:0] off);
      sfr_req_i.sel && sfr_req_i.wr && sfr_req_i.addr == {4'h0, off};
   endsequence
   sequence s_xbus_hit;
      xbus_req_i.sel && xbus_req_i.addr == {4'h0, FCM_OFF_UNPROT};
   endsequence

   // ==========================================================
   // internal bus checks
   a_bitop_refused: assert property (
      internal_memory_bus_req_i.sel && internal_memory_bus_req_i.bitop && idx >= 0
      |=> internal_memory_bus_ans_o == FCM_ANS_REF && $stable(regs_r[0]))
      else $error("bit operation not refused");
   a_bitop_nowrite: assert property (
      internal_memory_bus_req_i.sel && internal_memory_bus_req_i.bitop && idx >= 0
      |-> regs_nxt[idx] == regs_r[idx])
      else $error("bit operation changes a flash word");
   a_internal_memory_bus_write: assert property (
      internal_memory_bus_req_i.sel && internal_memory_bus_req_i.wr && !internal_memory_bus_req_i.bitop
      && internal_memory_bus_req_i.addr == FCM_OFF_FLASH_CONTROL0_LOW
      |=> flash_control0_low_o == $past(internal_memory_bus_req_i.wdata))
      else $error("flash control word not written");
   a_internal_memory_bus_unmapped: assert property (
      internal_memory_bus_req_i.sel && idx < 0
      |=> internal_memory_bus_ack_o && internal_memory_bus_ans_o == FCM_ANS_UNM)
      else $error("internal bus decoded wrong address");
   a_internal_memory_bus_idle: assert property (
      !internal_memory_bus_req_i.sel |=> !internal_memory_bus_ack_o && internal_memory_bus_rdata_o == 16'h0000)
      else $error("internal bus answered without request");

   // ==========================================================
   // peripheral bus checks, window enable seen after the sync
   a_xbus_ack: assert property (
      xbus_req_i.sel |=> xbus_ack_o)
      else $error("peripheral bus request not acknowledged");
   a_xbus_unmapped: assert property (
      xbus_req_i.sel && xbus_req_i.addr[15:0] != FCM_OFF_UNPROT
      |=> xbus_ack_o && xbus_ans_o == FCM_ANS_UNM)
      else $error("peripheral bus decoded wrong address");
   a_window_gate: assert property (
      s_xbus_hit ##0 (xbus_req_i.wr && !misc_s2_r)
      |=> $stable(unprot_r) && xbus_ans_o == FCM_ANS_REF)
      else $error("unprotect written with window closed");
   a_window_read: assert property (
      s_xbus_hit ##0 (!xbus_req_i.wr && !misc_s2_r)
      |=> xbus_ans_o == FCM_ANS_REF && xbus_rdata_o == 16'h0000)
      else $error("unprotect read with window closed");
   a_unprot_write: assert property (
      s_xbus_hit ##0 (xbus_req_i.wr && !xbus_req_i.bitop && misc_s2_r)
      |=> volatile_unprotect_temp_o == $past(xbus_req_i.wdata))
      else $error("unprotect word not written");
   a_xbus_bitop: assert property (
      s_xbus_hit ##0 (xbus_req_i.bitop && misc_s2_r)
      |=> xbus_ans_o == FCM_ANS_REF && $stable(unprot_r))
      else $error("bit operation on unprotect word not refused");

   // ==========================================================
   // id space checks
   a_maker_code: assert property (
      s_id_read(FCM_OFF_ID_MAKER)
      |=> sfr_rdata_o[15:5] == FCM_MAKER_CODE)
      else $error("maker code wrong");
   a_chip_code: assert property (
      s_id_read(FCM_OFF_ID_CHIP)
      |=> sfr_rdata_o[15:4] == FCM_DEVICE_CODE
      && sfr_rdata_o[3:0] == FCM_REVISION)
      else $error("chip id wrong");
   a_mem_size: assert property (
      s_id_read(FCM_OFF_ID_MEM)
      |=> sfr_rdata_o[15:12] == FCM_CAPACITY)
      else $error("memory size wrong");
   a_mem_kind: assert property (
      s_id_read(FCM_OFF_ID_MEM)
      |=> sfr_rdata_o[11:0] == FCM_KIND_SFLASH)
      else $error("memory type wrong");
   a_ext_supply: assert property (
      s_id_read(FCM_OFF_ID_PROG)
      |=> sfr_rdata_o[15:8] == 8'h00)
      else $error("external supply byte not zero");
   a_core_supply: assert property (
      s_id_read(FCM_OFF_ID_PROG)
      |=> sfr_rdata_o[7:0] == FCM_CORE_SUPPLY)
      else $error("core supply byte wrong");
   a_id_write_ok: assert property (
      s_id_write(FCM_OFF_ID_MEM) ##1 s_id_read(FCM_OFF_ID_MEM)
      |=> sfr_ans_o == FCM_ANS_OK && sfr_rdata_o == ID_MEM)
      else $error("id word altered by write");
   a_id_prog_kept: assert property (
      s_id_write(FCM_OFF_ID_PROG) ##1 s_id_read(FCM_OFF_ID_PROG)
      |=> sfr_rdata_o == ID_PROG)
      else $error("programming voltage word altered by write");
   a_id_write_ans: assert property (
      s_id_write(FCM_OFF_ID_CHIP)
      |=> sfr_ack_o && sfr_ans_o == FCM_ANS_OK && sfr_rdata_o == 16'h0000)
      else $error("id write not completed quietly");
   a_sfr_ack: assert property (
      sfr_req_i.sel |=> sfr_ack_o)
      else $error("id space request not acknowledged");
   a_sfr_idle: assert property (
      !sfr_req_i.sel |=> !sfr_ack_o && sfr_rdata_o == 16'h0000)
      else $error("id space answered without request");
   a_id_count: assert property (
      sfr_req_i.sel && sfr_req_i.addr[15:4] != 12'hf07
      |=> sfr_ans_o == FCM_ANS_UNM)
      else $error("id space decoded too widely");
endmodule

// file: sim/tb_flash_ctrl_map_and_id_regs.sv
// Purpose: self-checking bench for the flash register map and id words
// Assumes: one request per bus per cycle, answer one cycle after it
// Notes  : inputs change on the falling edge, results read after rising
`timescale 1ns/100ps
module tb_flash_ctrl_map_and_id_regs;
   import fcm_pkg::*;
   // ==========================================================
   // signals and reference model
   logic        clock_i   = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        win       = 1'b0;
   fcm_req_t    ib        = '0;
   fcm_req_t    xb        = '0;
   fcm_req_t    sb        = '0;
   logic        ib_ack, xb_ack, sb_ack;
   fcm_ans_t    ib_ans, xb_ans, sb_ans;
   logic [15:0] ib_rd, xb_rd, sb_rd, fc0l, unp;
   int          errors   = 0;
   int          n_checks = 0;
   int          k;
   logic [15:0] d;
   logic [15:0] m_unp;
   logic [15:0] mdl [logic [19:0]];
   logic [15:0] idv [logic [19:0]];
   logic [19:0] fl_addr [15] = '{FCM_OFF_FLASH_CONTROL0_LOW, FCM_OFF_FLASH_CONTROL0_HIGH,
      FCM_OFF_FLASH_CONTROL1_LOW, FCM_OFF_FLASH_CONTROL1_HIGH, FCM_OFF_FLASH_DATA0_LOW, FCM_OFF_FLASH_DATA0_HIGH,
      FCM_OFF_FLASH_DATA1_LOW, FCM_OFF_FLASH_DATA1_HIGH, FCM_OFF_FLASH_ADDRESS_LOW, FCM_OFF_FLASH_ADDRESS_HIGH,
      FCM_OFF_FER, FCM_OFF_NVWP, FCM_OFF_NVAP0, FCM_OFF_NVAP1L,
      FCM_OFF_NVAP1H};
   logic [15:0] fl_rst [15] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0000, 16'h0000,
      16'h0000, 16'hffff, 16'hacff, 16'hffff, 16'hffff};
   localparam logic [19:0] UNP = {4'h0, FCM_OFF_UNPROT};

   always #20 clock_i = ~clock_i;

   fcm_regs dut (
      .clock_i                   (clock_i),
      .sys_rst_i                 (sys_rst_i),
      .internal_memory_bus_req_i                (ib),
      .xbus_req_i                (xb),
      .sfr_req_i                 (sb),
      .misc_window_enable_i      (win),
      .internal_memory_bus_ack_o                (ib_ack),
      .internal_memory_bus_ans_o                (ib_ans),
      .internal_memory_bus_rdata_o              (ib_rd),
      .xbus_ack_o                (xb_ack),
      .xbus_ans_o                (xb_ans),
      .xbus_rdata_o              (xb_rd),
      .sfr_ack_o                 (sb_ack),
      .sfr_ans_o                 (sb_ans),
      .sfr_rdata_o               (sb_rd),
      .flash_control0_low_o      (fc0l),
      .volatile_unprotect_temp_o (unp)
   );
   // ==========================================================
   // helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      if (errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic rst_model();
      foreach (fl_addr[i]) mdl[fl_addr[i]] = fl_rst[i];
      m_unp = 16'h0000;
   endtask

   // model computes the answer, then one request is driven and checked
   task automatic op(input int bus, input logic wr, input logic bo,
                     input logic [19:0] a, input logic [15:0] wd);
      fcm_req_t    r;
      fcm_ans_t    ea;
      logic [15:0] ed;
      logic        ack;
      fcm_ans_t    ans;
      logic [15:0] rd;
      r = '{sel: 1'b1, wr: wr, bitop: bo, addr: a, wdata: wd};
      ea = FCM_ANS_UNM;
      ed = 16'h0000;
      if (bus == 0 && mdl.exists(a)) begin
         ea = bo ? FCM_ANS_REF : FCM_ANS_OK;
         if (!bo && wr) mdl[a] = wd;
         else if (!bo) ed = mdl[a];
      end else if (bus == 1 && a == UNP) begin
         ea = (!win || bo) ? FCM_ANS_REF : FCM_ANS_OK;
         if (ea == FCM_ANS_OK && wr) m_unp = wd;
         else if (ea == FCM_ANS_OK) ed = m_unp;
      end else if (bus == 2 && idv.exists(a)) begin
         ea = FCM_ANS_OK;
         if (!wr) ed = idv[a];
      end
      @(negedge clock_i);
      ib = (bus == 0) ? r : '0;
      xb = (bus == 1) ? r : '0;
      sb = (bus == 2) ? r : '0;
      @(posedge clock_i);
      #1;
      ack = (bus == 0) ? ib_ack : (bus == 1) ? xb_ack : sb_ack;
      ans = (bus == 0) ? ib_ans : (bus == 1) ? xb_ans : sb_ans;
      rd  = (bus == 0) ? ib_rd : (bus == 1) ? xb_rd : sb_rd;
      chk({15'h0000, ack}, 16'h0001);
      chk({14'h0000, ans}, {14'h0000, ea});
      chk(rd, ed);
      chk(fc0l, mdl[FCM_OFF_FLASH_CONTROL0_LOW]);
      chk(unp, m_unp);
   endtask

   // drops every request, then lets the enable pass the two-flop sync
   task automatic set_win(input logic v);
      @(negedge clock_i);
      ib = '0;
      xb = '0;
      sb = '0;
      win = v;
      repeat (3) @(negedge clock_i);
   endtask

   task automatic do_reset();
      @(negedge clock_i);
      ib = '0;
      xb = '0;
      sb = '0;
      sys_rst_i = 1'b1;
      repeat (10) @(negedge clock_i);
      sys_rst_i = 1'b0;
      rst_model();
   endtask
   // ==========================================================
   // watchdog: the whole sequence needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge clock_i);
      errors++;
      print_verdict();
   end
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(91328));
      idv[{4'h0, FCM_OFF_ID_MAKER}] = {FCM_MAKER_CODE, 5'h00};
      idv[{4'h0, FCM_OFF_ID_CHIP}]  = {FCM_DEVICE_CODE, FCM_REVISION};
      idv[{4'h0, FCM_OFF_ID_MEM}]   = {FCM_CAPACITY, 12'h002};
      idv[{4'h0, FCM_OFF_ID_PROG}]  = {8'h00, FCM_CORE_SUPPLY};
      do_reset();
      foreach (fl_addr[i]) op(0, 1'b0, 1'b0, fl_addr[i], 16'h0000);
      foreach (fl_addr[i]) begin
         d = 16'($urandom);
         op(0, 1'b1, 1'b0, fl_addr[i], d);
         op(0, 1'b1, 1'b1, fl_addr[i], ~d);
         op(0, 1'b0, 1'b1, fl_addr[i], 16'h0000);
         op(0, 1'b0, 1'b0, fl_addr[i], 16'h0000);
      end
      op(0, 1'b0, 1'b0, 20'h80016, 16'h0000);
      op(0, 1'b1, 1'b0, UNP, 16'h1234);
      op(1, 1'b0, 1'b0, 20'h0eb52, 16'h0000);
      op(1, 1'b1, 1'b0, UNP, 16'($urandom));
      set_win(1'b1);
      d = 16'($urandom);
      op(1, 1'b1, 1'b0, UNP, d);
      op(1, 1'b0, 1'b0, UNP, 16'h0000);
      op(1, 1'b1, 1'b1, UNP, ~d);
      op(1, 1'b0, 1'b0, UNP, 16'h0000);
      set_win(1'b0);
      op(1, 1'b0, 1'b0, UNP, 16'h0000);
      foreach (idv[a]) begin
         op(2, 1'b0, 1'b0, a, 16'h0000);
         op(2, 1'b1, 1'b0, a, 16'($urandom));
         op(2, 1'b0, 1'b0, a, 16'h0000);
         op(0, 1'b0, 1'b0, a, 16'h0000);
      end
      op(2, 1'b0, 1'b0, 20'h0f07e, 16'h0000);
      op(2, 1'b0, 1'b0, 20'h0f080, 16'h0000);
      op(2, 1'b0, 1'b0, 20'h1f070, 16'h0000);
      repeat (80) begin
         k = $urandom_range(14);
         op(0, 1'($urandom), ($urandom_range(3) == 0), fl_addr[k],
            16'($urandom));
      end
      do_reset();
      foreach (fl_addr[i]) op(0, 1'b0, 1'b0, fl_addr[i], 16'h0000);
      op(1, 1'b0, 1'b0, UNP, 16'h0000);
      print_verdict();
   end
endmodule
